//--- rtl/adcsq_cfg.svh
`ifndef ADCSQ_CFG_SVH
`define ADCSQ_CFG_SVH

// register byte addresses on the avalon word bus
`define ADCSQ_ADDR_RES_LO    4'h0
`define ADCSQ_ADDR_RES_HI    4'h4
`define ADCSQ_ADDR_CTRL_A    4'h8
`define ADCSQ_ADDR_CTRL_B    4'hc
`define ADCSQ_ADDR_EVENT     4'h4

// control a field positions
`define ADCSQ_A_START        7
`define ADCSQ_A_BUSY         6
`define ADCSQ_A_EN           5
`define ADCSQ_A_FMT          4
// control b field positions
`define ADCSQ_B_SRC_LSB      5
`define ADCSQ_B_VREF_LSB     3
`define ADCSQ_B_CLK_LSB      0

`define ADCSQ_CTRL_RST       8'h00
`define ADCSQ_RES_RST        8'h00
`define ADCSQ_EXT_CH_LAST    4'h3
`define ADCSQ_CONV_CYCLES    16

`endif

//--- rtl/adcsq_pkg.sv
package adcsq_pkg;
  typedef logic [7:0]  adcsq_byte_t;
  typedef logic [11:0] adcsq_sample_t;
  typedef logic [3:0]  adcsq_addr_t;
  typedef enum logic [2:0] {
    ADCSQ_SRC_EXT,
    ADCSQ_SRC_AMP0,
    ADCSQ_SRC_AMP1,
    ADCSQ_SRC_AMP2,
    ADCSQ_SRC_DAC,
    ADCSQ_SRC_EXT5,
    ADCSQ_SRC_EXT6,
    ADCSQ_SRC_EXT7
  } adcsq_src_e;
  typedef enum logic [1:0] {
    ADCSQ_IDLE,
    ADCSQ_HELD,
    ADCSQ_CONV
  } adcsq_state_e;
endpackage

//--- rtl/adcsq_clkdiv.sv
`timescale 1ns/1ns
`default_nettype none
// produces one-cycle ticks at core_clk / 2**sel
module adcsq_clkdiv
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       clear,
  input  wire logic [2:0] sel,
  output logic            tick
);
  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  logic [6:0] limit;

  always_comb
  begin
    limit = 7'((8'h01 << sel) - 8'h01);
    if (clear || cnt_reg >= limit)
      cnt_next = 7'h00;
    else
      cnt_next = cnt_reg + 7'h01;
    tick = !clear && (cnt_reg >= limit);
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      cnt_reg <= 7'h00;
    else if (clk_en)
      cnt_reg <= cnt_next;
  end
endmodule // adcsq_clkdiv
`default_nettype wire

//--- rtl/adcsq_regs.sv
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "adcsq_cfg.svh"
// Notes on behaviour
// - a conversion starts only after start bit is written high then low
// - while start is high the converter core is held in reset
// - busy flag goes to 1 once a conversion has been started
// - busy flag returns to 0 when the conversion finishes
// - busy flag is read only; writes to its bit are ignored
// - enable bit powers the converter; zero switches it off
// - while disabled both result bytes keep their old contents
// - format 0 left justifies: high byte D11..4, low byte D3..0 on top
// - format 1 right justifies: high byte D11..8 low, low byte D7..0
// - result bits not holding sample data read as zero
// - channel codes 0..3 pick external inputs, 4..15 leave path floating
// - each conversion yields a 12-bit value from the selected source
// - a pin used as converter input loses its io function and pull-high
// - first control register resets to all zeros
// - source field: 0,5,6,7 external; 1..3 amplifiers; 4 converter output
// - conversion clock is system clock divided by 2 to the field value
// - end of conversion sets the request flag and raises an interrupt; here conv_irq only rises while int_enable is high
module adcsq_regs
  import adcsq_pkg::*;
#(
  parameter int CONV_CYCLES = `ADCSQ_CONV_CYCLES
)
(
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 clk_en,
  input  wire adcsq_pkg::adcsq_addr_t avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  input  wire adcsq_pkg::adcsq_sample_t core_data,
  input  wire logic                 int_enable,
  output logic                      core_reset,
  output logic                      core_power,
  output logic                      core_sample,
  output logic                      core_clk_tick,
  output logic [3:0]                ext_analog_inputs,
  output logic                      amp_out_0,
  output logic                      amp_out_1,
  output logic                      amp_out_2,
  output logic                      dac_output,
  output logic [1:0]                vref_sel,
  output logic [3:0]                pin_analog_mode,
  output logic                      conv_irq_flag,
  output logic                      conv_irq
);
  import adcsq_pkg::*;

  adcsq_byte_t   ctrl_a_reg, ctrl_a_next;
  adcsq_byte_t   ctrl_b_reg, ctrl_b_next;
  adcsq_byte_t   res_lo_reg, res_lo_next;
  adcsq_byte_t   res_hi_reg, res_hi_next;
  adcsq_state_e  state_reg, state_next;
  logic [15:0]   cyc_reg, cyc_next;
  logic          flag_reg, flag_next;
  logic          irq_reg, irq_next;
  logic          ack_reg, ack_next;
  // registered copies so that waitrequest and the tick pin leave a flop
  logic          wait_reg, wait_next;
  logic          tick_reg, tick_next;
  logic [31:0]   rdata_reg, rdata_next;
  logic          sample_reg, sample_next;
  logic [3:0]    sel_reg, sel_next;
  logic [4:0]    src_reg, src_next;
  logic          tick;
  logic          wr_a, wr_b, rd_ev, done;
  adcsq_byte_t   wdata;
  adcsq_src_e    src;

  assign wdata = avs_writedata[7:0];
  // a write lands at the edge where waitrequest is low, the one edge the master commits on
  assign wr_a  = avs_write && ack_reg && avs_byteenable[0] && avs_address == `ADCSQ_ADDR_CTRL_A;
  assign wr_b  = avs_write && ack_reg && avs_byteenable[0] && avs_address == `ADCSQ_ADDR_CTRL_B;
  assign rd_ev = avs_read && !ack_reg && avs_address == `ADCSQ_ADDR_EVENT;
  assign src   = adcsq_src_e'(ctrl_b_reg[`ADCSQ_B_SRC_LSB +: 3]);

  // the divider is held cleared outside a conversion, so every conversion sees whole ticks
  adcsq_clkdiv u_div
  (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .clear    (state_reg != ADCSQ_CONV),
    .sel      (ctrl_b_reg[`ADCSQ_B_CLK_LSB +: 3]),
    .tick     (tick)
  );

  // a disable or a new start in the last tick must not load a result or pulse the core
  assign done = (state_reg == ADCSQ_CONV) && ctrl_a_reg[`ADCSQ_A_EN] && !ctrl_a_reg[`ADCSQ_A_START]
                && tick && (cyc_reg == 16'(CONV_CYCLES - 1));

  // sequencer
  // held follows the start bit; the conversion begins on its fall
  always_comb
  begin
    state_next = state_reg;
    cyc_next   = cyc_reg;
    case (state_reg)
      ADCSQ_IDLE:
        if (ctrl_a_reg[`ADCSQ_A_START])
          state_next = ADCSQ_HELD;
      ADCSQ_HELD:
        if (!ctrl_a_reg[`ADCSQ_A_START])
        begin
          state_next = ctrl_a_reg[`ADCSQ_A_EN] ? ADCSQ_CONV : ADCSQ_IDLE;
          cyc_next   = 16'h0000;
        end
      ADCSQ_CONV:
        if (ctrl_a_reg[`ADCSQ_A_START])
          state_next = ADCSQ_HELD;
        else if (!ctrl_a_reg[`ADCSQ_A_EN])
          state_next = ADCSQ_IDLE;
        else if (done)
          state_next = ADCSQ_IDLE;
        else if (tick)
          cyc_next = cyc_reg + 16'h0001;
      default:
        state_next = ADCSQ_IDLE;
    endcase
  end

  // the tick counter restarts on every way into a conversion
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ADCSQ_IDLE;
      cyc_reg   <= 16'h0000;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      cyc_reg   <= cyc_next;
    end
  end

  // registers seen by software
  always_comb
  begin
    ctrl_a_next = ctrl_a_reg;
    ctrl_b_next = ctrl_b_reg;
    res_lo_next = res_lo_reg;
    res_hi_next = res_hi_reg;
    flag_next   = flag_reg;
    if (wr_a)
    begin
      ctrl_a_next = wdata;
      ctrl_a_next[`ADCSQ_A_BUSY] = ctrl_a_reg[`ADCSQ_A_BUSY];
    end
    if (wr_b)
      ctrl_b_next = wdata;
    if (state_next == ADCSQ_CONV)
      ctrl_a_next[`ADCSQ_A_BUSY] = 1'b1;
    else
      ctrl_a_next[`ADCSQ_A_BUSY] = 1'b0;
    // clear first, so an end of conversion in the same cycle wins
    if (rd_ev)
      flag_next = 1'b0;
    if (done && ctrl_a_reg[`ADCSQ_A_EN])
    begin
      flag_next = 1'b1;
      if (ctrl_a_reg[`ADCSQ_A_FMT])
      begin
        res_hi_next = {4'h0, core_data[11:8]};
        res_lo_next = core_data[7:0];
      end
      else
      begin
        res_hi_next = core_data[11:4];
        res_lo_next = {core_data[3:0], 4'h0};
      end
    end
  end

  // both result bytes sit in one group so they always change on the same edge
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_a_reg <= `ADCSQ_CTRL_RST;
      ctrl_b_reg <= `ADCSQ_CTRL_RST;
      res_lo_reg <= `ADCSQ_RES_RST;
      res_hi_reg <= `ADCSQ_RES_RST;
      flag_reg   <= 1'b0;
    end
    else if (clk_en)
    begin
      ctrl_a_reg <= ctrl_a_next;
      ctrl_b_reg <= ctrl_b_next;
      res_lo_reg <= res_lo_next;
      res_hi_reg <= res_hi_next;
      flag_reg   <= flag_next;
    end
  end

  // bus answer: one wait cycle, so read data always leaves a flop
  always_comb
  begin
    ack_next   = (avs_read || avs_write) && !ack_reg;
    wait_next  = !ack_next;
    rdata_next = rdata_reg;
    // a read clears the end flag at its capture edge, so no event slips in between
    if (avs_read && !ack_reg)
      case (avs_address)
        `ADCSQ_ADDR_RES_LO: rdata_next = {24'h0, res_lo_reg};
        `ADCSQ_ADDR_RES_HI: rdata_next = {22'h0, irq_reg, flag_reg, res_hi_reg};
        `ADCSQ_ADDR_CTRL_A: rdata_next = {24'h0, ctrl_a_reg};
        `ADCSQ_ADDR_CTRL_B: rdata_next = {24'h0, ctrl_b_reg};
        default:            rdata_next = 32'h0;
      endcase
  end

  // waitrequest rests high, so an idle bus never sees a false answer
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ack_reg   <= 1'b0;
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0;
    end
    else if (clk_en)
    begin
      ack_reg   <= ack_next;
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  // pin-side selects and event outputs
  always_comb
  begin
    irq_next    = flag_next && int_enable;
    sample_next = done;
    tick_next   = tick;
    src_next    = 5'h00;
    sel_next    = 4'h0;
    // internal sources are routed only while the converter is enabled
    if (ctrl_a_reg[`ADCSQ_A_EN])
    begin
      case (src)
        ADCSQ_SRC_AMP0: src_next = 5'h01;
        ADCSQ_SRC_AMP1: src_next = 5'h02;
        ADCSQ_SRC_AMP2: src_next = 5'h04;
        ADCSQ_SRC_DAC:  src_next = 5'h08;
        default:        src_next = 5'h10;
      endcase
    end
    // floating codes simply select no pin
    if (src_next[4] && ctrl_a_reg[3:0] <= `ADCSQ_EXT_CH_LAST)
      sel_next = 4'(4'h1 << ctrl_a_reg[1:0]);
  end

  // the tick copy lets the core follow the conversion clock without a second clock net
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_reg    <= 1'b0;
      sample_reg <= 1'b0;
      tick_reg   <= 1'b0;
      sel_reg    <= 4'h0;
      src_reg    <= 5'h00;
    end
    else if (clk_en)
    begin
      irq_reg    <= irq_next;
      sample_reg <= sample_next;
      tick_reg   <= tick_next;
      sel_reg    <= sel_next;
      src_reg    <= src_next;
    end
  end

  // waitrequest stays high until the registered answer cycle
  // every output leaves a flop, so the analog side never sees decode glitches
  assign avs_waitrequest   = wait_reg;
  assign avs_readdata      = rdata_reg;
  assign core_reset        = ctrl_a_reg[`ADCSQ_A_START];
  assign core_power        = ctrl_a_reg[`ADCSQ_A_EN];
  assign core_sample       = sample_reg;
  assign core_clk_tick     = tick_reg;
  assign ext_analog_inputs = sel_reg;
  assign pin_analog_mode   = sel_reg;
  assign amp_out_0         = src_reg[0];
  assign amp_out_1         = src_reg[1];
  assign amp_out_2         = src_reg[2];
  assign dac_output        = src_reg[3];
  assign vref_sel          = ctrl_b_reg[`ADCSQ_B_VREF_LSB +: 2];
  assign conv_irq_flag     = flag_reg;
  assign conv_irq          = irq_reg;
endmodule // adcsq_regs
`default_nettype wire

//--- bench/adcsq_regs_checker.sv
`timescale 1ns/1ns
`default_nettype none
`include "adcsq_cfg.svh"
module adcsq_regs_checker
  import adcsq_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire adcsq_addr_t avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic        core_reset,
  input wire logic        core_power,
  input wire logic        core_sample,
  input wire logic [3:0]  ext_analog_inputs,
  input wire logic [3:0]  pin_analog_mode,
  input wire logic        conv_irq_flag,
  input wire logic        conv_irq,
  input wire logic        int_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic wr_a = avs_write && !avs_waitrequest && avs_address == `ADCSQ_ADDR_CTRL_A && avs_byteenable[0];
  property p_rst;
    $fell(rst) |-> !core_reset && !core_power && !conv_irq_flag && avs_waitrequest;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_start;
    wr_a |=> core_reset == $past(avs_writedata[7]);
  endproperty
  a_start: assert property (p_start) else $error("start bit not applied");
  property p_en;
    wr_a |=> core_power == $past(avs_writedata[5]);
  endproperty
  a_en: assert property (p_en) else $error("enable bit not applied");
  property p_hold;
    core_reset |-> !core_sample;
  endproperty
  a_hold: assert property (p_hold) else $error("conversion ended while held");
  property p_pulse;
    core_sample |=> !core_sample;
  endproperty
  a_pulse: assert property (p_pulse) else $error("sample pulse too long");
  property p_flag;
    core_sample |-> conv_irq_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("end flag missing");
  property p_irq;
    1'b1 |-> conv_irq == (conv_irq_flag && $past(int_enable));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt wrong");
  property p_sel;
    $onehot0(ext_analog_inputs) && pin_analog_mode == ext_analog_inputs;
  endproperty
  a_sel: assert property (p_sel) else $error("pin select wrong");
  c_conv: cover property (core_sample);
  c_irq: cover property (conv_irq);
  c_start: cover property ($fell(core_reset));
endmodule // adcsq_regs_checker
bind adcsq_regs adcsq_regs_checker adcsq_regs_checker_inst (.*);
`default_nettype wire

//--- bench/adcsq_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module adcsq_core_model
(
  input  wire logic                     core_clk,
  input  wire logic                     core_reset,
  input  wire logic                     core_power,
  input  wire adcsq_pkg::adcsq_sample_t value,
  output adcsq_pkg::adcsq_sample_t      core_data = 12'ha5a
);
  import adcsq_pkg::*;
  // an idle or held core shows a changing pattern so stale data never looks valid
  always @(posedge core_clk)
    if (!core_power || core_reset)
      core_data <= ~core_data;
    else
      core_data <= value;
endmodule // adcsq_core_model
`default_nettype wire

//--- bench/adc_sequencer_regs_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "adcsq_cfg.svh"
module adc_sequencer_regs_test;
  import adcsq_pkg::*;
  logic          core_clk = 0, rst = 1, avs_read = 0, avs_write = 0, int_enable = 0;
  adcsq_addr_t   avs_address = 4'h0;
  logic [31:0]   avs_writedata = 32'h0, avs_readdata;
  logic          avs_waitrequest, core_reset, core_power, core_sample;
  logic [3:0]    ext_analog_inputs;
  logic          conv_irq_flag, conv_irq;
  time           t0;
  logic          amp_out_0, amp_out_1, amp_out_2, dac_output;
  adcsq_sample_t core_data, value = 12'h0;
  adcsq_byte_t   exp_q[$];
  adcsq_byte_t   hi, lo, ctl;
  int            bad_count = 0, n_tests = 0, cyc = 0, seed = 25;
  always #50 core_clk = ~core_clk;
  adcsq_regs adcsq_regs_inst (.core_clk, .rst, .clk_en(1'b1), .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .core_data, .int_enable,
    .core_reset, .core_power, .core_sample, .core_clk_tick(), .ext_analog_inputs, .amp_out_0,
    .amp_out_1, .amp_out_2, .dac_output, .vref_sel(), .pin_analog_mode(), .conv_irq_flag, .conv_irq);
  adcsq_core_model adcsq_core_model_inst (.core_clk, .core_reset, .core_power, .value, .core_data);
  task summarize;
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task check(input adcsq_byte_t seen, input adcsq_byte_t exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask
  // request held until waitrequest is seen low at an edge
  task acc(input logic w, input adcsq_addr_t a, input adcsq_byte_t d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task rd(input adcsq_addr_t a, input adcsq_byte_t e);
    exp_q.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask
  always @(posedge core_clk)
    if (avs_read && !avs_waitrequest && exp_q.size() > 0)
      check(avs_readdata[7:0], exp_q.pop_front(), "readdata");
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      summarize();
    end
  end
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rd(`ADCSQ_ADDR_CTRL_A, `ADCSQ_CTRL_RST);
    rd(4'h2, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 5; i++)
    begin
      value <= 12'($random(seed));
      int_enable <= i[0];
      ctl = {2'b00, 1'b1, i[0], 4'(i * 5)};
      acc(1'b1, `ADCSQ_ADDR_CTRL_B, {3'(i), 2'h0, 3'(i % 3)});
      acc(1'b1, `ADCSQ_ADDR_CTRL_A, ctl | 8'h80);
      acc(1'b1, `ADCSQ_ADDR_CTRL_A, ctl | 8'h40);
      t0 = $time;
      rd(`ADCSQ_ADDR_CTRL_A, ctl | 8'h40);
      do @(posedge core_clk); while (core_sample !== 1'b1);
      // one edge to enter the conversion and one for the registered end pulse
      check(8'(($time - t0) / 100), 8'(2 + `ADCSQ_CONV_CYCLES * (1 << (i % 3))), "duration");
      check({6'h00, conv_irq, conv_irq_flag}, {6'h00, i[0], 1'b1}, "end event");
      rd(`ADCSQ_ADDR_CTRL_A, ctl);
      hi = i[0] ? {4'h0, value[11:8]} : value[11:4];
      lo = i[0] ? value[7:0] : {value[3:0], 4'h0};
      rd(`ADCSQ_ADDR_RES_HI, hi);
      rd(`ADCSQ_ADDR_RES_LO, lo);
      check({dac_output, amp_out_2, amp_out_1, amp_out_0, ext_analog_inputs},
        {i == 4, i == 3, i == 2, i == 1, i == 0 ? 4'h1 : 4'h0}, "source");
      $display("conversion test %0d done", i);
    end
    // disabling in mid-conversion must abort it and leave the last result in place
    acc(1'b1, `ADCSQ_ADDR_CTRL_A, 8'ha0);
    acc(1'b1, `ADCSQ_ADDR_CTRL_A, 8'h20);
    value <= ~value;
    acc(1'b1, `ADCSQ_ADDR_CTRL_A, 8'h40);
    repeat (40) @(posedge core_clk);
    rd(`ADCSQ_ADDR_CTRL_A, 8'h00);
    rd(`ADCSQ_ADDR_RES_HI, hi);
    rd(`ADCSQ_ADDR_RES_LO, lo);
    $display("abort test done");
    // starting while disabled must leave the last result in place
    acc(1'b1, `ADCSQ_ADDR_CTRL_A, 8'h80);
    acc(1'b1, `ADCSQ_ADDR_CTRL_A, 8'h00);
    repeat (40) @(posedge core_clk);
    rd(`ADCSQ_ADDR_CTRL_A, 8'h00);
    rd(`ADCSQ_ADDR_RES_HI, hi);
    rd(`ADCSQ_ADDR_RES_LO, lo);
    $display("disable test done");
    summarize();
  end
endmodule // adc_sequencer_regs_test
`default_nettype wire
